// ===== src/acs_pkg.sv
// What this block does
// - A conversion starts from a hardware start pulse or a software start bit write.
// - Hardware start rising edge enters hold and converts; an edge while settling is ignored, not deferred.
// - Every channel address load launches the settling pulse, shown on the cap pin.
// - The settling pulse goes low as soon as a serial write begins.
// - Settling countdown starts on the sixth serial clock falling edge of a write.
// - Hold entry and conversion start are blocked until settling ends.
// - Software starts always wait until the retriggered settling pulse has expired.
// - Conversion steps are paced only by the master clock input.
// - Conversion finishes within 5.9 us; then 2 us acquisition before next sample.
// - Self-clocking mode paces starts to at most 78 kHz.
// - Bipolar variant outputs twelve-bit twos complement, zero input gives zero code.
// - Unipolar variants output straight binary, zero at ground, all ones at top.
// - Software start bit set disables hardware start; clearing it re-enables it.
// - Register write takes effect after six serial clocks; early abort stores nothing.
// - Three address bits, most significant first, select one of eight channels.
// - Each conversion takes 14.5 master clock cycles, then the result register updates.
package acs_pkg;
   localparam int CLK_KHZ = 50000;
   localparam int CLK_PERIOD_NS = 20;
   localparam int CODE_W = 12;
   localparam int CHAN_W = 3;
   localparam int CTRL_BITS = 5;
   // Serial control word bit positions, first shifted bit is the channel msb
   localparam int POS_CHAN_MSB = 4;
   localparam int POS_SOFT_START = 1;
   localparam int POS_STANDBY = 0;
   localparam logic [2:0] LOAD_FALL_IDX = 3'h5;
   localparam logic [CTRL_BITS-1:0] CTRL_RESET = 5'h00;
   localparam logic [CODE_W-1:0] RESULT_RESET = 12'h000;
   localparam int SOFT_START_BIT_HALF_EDGES = 29;
   localparam int SOFT_START_BIT_MAX_NS = 5900;
   localparam int SOFT_START_BIT_MAX_CYCLES = SOFT_START_BIT_MAX_NS / CLK_PERIOD_NS;
   localparam int ACQ_NS = 2000;
   localparam int ACQ_CYCLES = (ACQ_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int SELF_MAX_RATE_KHZ = 78;
   localparam int SELF_PACE_CYCLES = (CLK_KHZ + SELF_MAX_RATE_KHZ - 1) / SELF_MAX_RATE_KHZ;
   localparam int SETTLE_DEFAULT_CYCLES = 50;
   typedef enum logic [1:0] {ST_TRACK, ST_CONVERT, ST_ACQUIRE} acs_state_type;
endpackage

`timescale 1ns/1ps
module acs_settle_timer #(
   parameter int SETTLE_CYCLES = acs_pkg::SETTLE_DEFAULT_CYCLES
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic write_begin,
   input wire logic write_abort,
   input wire logic discharge,
   output logic active
);
   import acs_pkg::*;
   localparam int CNT_W = $clog2(SETTLE_CYCLES + 1);
   localparam logic [CNT_W-1:0] LAST = CNT_W'(SETTLE_CYCLES - 1);
   logic holding;
   logic counting;
   logic [CNT_W-1:0] count;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         holding <= 1'b0;
      else if (write_begin)
         holding <= 1'b1;
      else if (discharge || write_abort)
         holding <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         counting <= 1'b0;
         count <= '0;
      end
      else if (discharge)
      begin
         counting <= 1'b1;
         count <= '0;
      end
      else if (write_begin)
         counting <= 1'b0;
      else if (counting)
      begin
         if (count == LAST)
            counting <= 1'b0;
         count <= count + 1'b1;
      end
   end

   assign active = holding || counting;
endmodule

// ===== src/acs_sequencer.sv
`timescale 1ns/1ps
module acs_sequencer #(
   parameter int SETTLE_CYCLES = acs_pkg::SETTLE_DEFAULT_CYCLES,
   parameter bit BIPOLAR = 1'b1
) (
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic hw_start_n,
   input wire logic write_frame_sync_n,
   input wire logic sclk,
   input wire logic sdata_in,
   input wire logic clk_in,
   input wire logic self_clock_mode,
   input wire logic [acs_pkg::CODE_W-1:0] sample_code,
   output logic settle_cap_pin,
   output logic [acs_pkg::CHAN_W-1:0] chan_sel,
   output logic soft_start_bit,
   output logic standby,
   output logic soft_start_bit_hold,
   output logic busy,
   output logic [acs_pkg::CODE_W-1:0] result,
   output logic done
);
   import acs_pkg::*;

   // Comparator code is offset binary; bipolar parts flip the msb
   function automatic logic [CODE_W-1:0] code_format(input logic [CODE_W-1:0] raw, input logic bip);
      code_format = bip ? {~raw[CODE_W-1], raw[CODE_W-2:0]} : raw;
   endfunction

   function automatic logic edge_of(input logic now, input logic prev, input logic rising);
      edge_of = rising ? (now && !prev) : (!now && prev);
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Serial control write
   logic fs_prev;
   logic sclk_prev;
   logic hws_prev;
   logic clkin_prev;
   logic write_active;
   logic [2:0] fall_cnt;
   logic [CTRL_BITS-1:0] shift;
   logic write_begin;
   logic write_abort;
   logic sclk_fall;
   logic load_pulse;
   logic [CTRL_BITS-1:0] next_ctrl;
   logic settle_active;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         fs_prev <= 1'b1;
         sclk_prev <= 1'b1;
         hws_prev <= 1'b1;
         clkin_prev <= 1'b0;
      end
      else
      begin
         fs_prev <= write_frame_sync_n;
         sclk_prev <= sclk;
         hws_prev <= hw_start_n;
         clkin_prev <= clk_in;
      end
   end

   assign write_begin = edge_of(write_frame_sync_n, fs_prev, 1'b0);
   // Frame end before the committing fall, fifth fall included, is an abort
   assign write_abort = write_active && write_frame_sync_n && (fall_cnt <= LOAD_FALL_IDX);
   assign sclk_fall = write_active && !write_frame_sync_n && edge_of(sclk, sclk_prev, 1'b0);
   assign load_pulse = sclk_fall && (fall_cnt == LOAD_FALL_IDX);
   assign next_ctrl = shift;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         write_active <= 1'b0;
         fall_cnt <= '0;
         shift <= CTRL_RESET;
      end
      else if (write_begin)
      begin
         write_active <= 1'b1;
         fall_cnt <= '0;
      end
      else if (write_frame_sync_n)
         write_active <= 1'b0;
      else if (sclk_fall)
      begin
         if (fall_cnt < LOAD_FALL_IDX)
         begin
            shift <= {shift[CTRL_BITS-2:0], sdata_in};
            fall_cnt <= fall_cnt + 3'h1;
         end
         else
            write_active <= 1'b0;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         chan_sel <= CTRL_RESET[POS_CHAN_MSB -: CHAN_W];
         soft_start_bit <= CTRL_RESET[POS_SOFT_START];
         standby <= CTRL_RESET[POS_STANDBY];
      end
      else if (load_pulse)
      begin
         chan_sel <= next_ctrl[POS_CHAN_MSB -: CHAN_W];
         soft_start_bit <= next_ctrl[POS_SOFT_START];
         standby <= next_ctrl[POS_STANDBY];
      end
   end

   acs_settle_timer #(
      .SETTLE_CYCLES(SETTLE_CYCLES)
   ) u_settle (
      .ref_clk(ref_clk),
      .rst(rst),
      .write_begin(write_begin),
      .write_abort(write_abort),
      .discharge(load_pulse),
      .active(settle_active)
   );

   assign settle_cap_pin = !settle_active;

   ////////////////////////////////////////////////////////////////////////////
   // Start arbitration and pacing
   acs_state_type state;
   logic soft_pending;
   logic pace_ok;
   logic [$clog2(SELF_PACE_CYCLES+1)-1:0] pace_cnt;
   logic start_ok;
   logic hw_go;
   logic soft_go;
   logic start;
   logic [4:0] half_cnt;
   logic clkin_edge;
   logic soft_start_bit_end;
   logic [$clog2(ACQ_CYCLES+1)-1:0] acq_cnt;
   logic [CODE_W-1:0] held_code;

   assign pace_ok = !self_clock_mode || (pace_cnt == '0);
   assign start_ok = (state == ST_TRACK) && !settle_active && pace_ok;
   assign hw_go = edge_of(hw_start_n, hws_prev, 1'b1) && !soft_start_bit && start_ok;
   assign soft_go = soft_pending && start_ok;
   assign start = hw_go || soft_go;

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         soft_pending <= 1'b0;
      else if (load_pulse && next_ctrl[POS_SOFT_START])
         soft_pending <= 1'b1;
      else if (soft_go)
         soft_pending <= 1'b0;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         pace_cnt <= '0;
      else if (start)
         pace_cnt <= ($bits(pace_cnt))'(SELF_PACE_CYCLES - 1);
      else if (pace_cnt != '0)
         pace_cnt <= pace_cnt - 1'b1;
   end

   ////////////////////////////////////////////////////////////////////////////
   // Conversion sequence
   assign clkin_edge = clk_in != clkin_prev;
   assign soft_start_bit_end = (state == ST_CONVERT) && clkin_edge && (half_cnt == 5'(SOFT_START_BIT_HALF_EDGES - 1));

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         state <= ST_TRACK;
         half_cnt <= '0;
         acq_cnt <= '0;
      end
      else
      begin
         case (state)
            ST_TRACK:
               if (start)
               begin
                  state <= ST_CONVERT;
                  half_cnt <= '0;
               end
            ST_CONVERT:
               if (soft_start_bit_end)
               begin
                  state <= ST_ACQUIRE;
                  acq_cnt <= '0;
               end
               else if (clkin_edge)
                  half_cnt <= half_cnt + 5'h01;
            ST_ACQUIRE:
               if (acq_cnt == ($bits(acq_cnt))'(ACQ_CYCLES - 1))
                  state <= ST_TRACK;
               else
                  acq_cnt <= acq_cnt + 1'b1;
            default:
               state <= ST_TRACK;
         endcase
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
         held_code <= RESULT_RESET;
      else if (start)
         held_code <= sample_code;
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         result <= RESULT_RESET;
         done <= 1'b0;
      end
      else
      begin
         done <= soft_start_bit_end;
         if (soft_start_bit_end)
            result <= code_format(held_code, BIPOLAR);
      end
   end

   assign soft_start_bit_hold = state == ST_CONVERT;
   assign busy = state != ST_TRACK;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   logic [15:0] since_start;
   always_ff @(posedge ref_clk)
   begin
      if (rst)
         since_start <= 16'hFFFF;
      else if (start)
         since_start <= 16'h0000;
      else if (since_start != 16'hFFFF)
         since_start <= since_start + 16'h0001;
   end

   a_hold_needs_settle: assert property (@(posedge ref_clk) disable iff (rst)
      $rose(soft_start_bit_hold) |-> !$past(settle_active)) else $error("Hold entered while settling");
   a_cap_low_write: assert property (@(posedge ref_clk) disable iff (rst)
      write_begin |=> !settle_cap_pin) else $error("Cap pin not low at write start");
   a_load_relaunch: assert property (@(posedge ref_clk) disable iff (rst)
      load_pulse |=> settle_active [*2]) else $error("Settling not running after load");
   a_abort_no_store: assert property (@(posedge ref_clk) disable iff (rst)
      write_abort |=> $stable(chan_sel) && $stable(soft_start_bit)) else $error("Aborted write stored");
   a_soft_blocks_hw: assert property (@(posedge ref_clk) disable iff (rst)
      soft_start_bit && !soft_pending && state == ST_TRACK |=> state == ST_TRACK) else $error("Hw start not ignored");
   a_acq_hold_off: assert property (@(posedge ref_clk) disable iff (rst)
      done |-> (state == ST_ACQUIRE && !soft_start_bit_hold) ##1 (state == ST_ACQUIRE) [*8]) else $error("Acquisition cut short");
   a_self_pace: assert property (@(posedge ref_clk) disable iff (rst)
      start && self_clock_mode |-> since_start >= 16'(SELF_PACE_CYCLES)) else $error("Self mode start too soon");
   a_done_format: assert property (@(posedge ref_clk) disable iff (rst)
      done |-> result == (BIPOLAR ? {~$past(held_code[CODE_W-1]), $past(held_code[CODE_W-2:0])}
                                  : $past(held_code))) else $error("Result coding wrong");
   a_soft_waits: assert property (@(posedge ref_clk) disable iff (rst)
      soft_go |-> !settle_active && $past(soft_pending)) else $error("Soft start before settle end");
endmodule

// ===== testbench/acs_host_model.sv
`timescale 1ns/1ps
module acs_host_model (
   input wire logic ref_clk,
   output logic hw_start_n,
   output logic write_frame_sync_n,
   output logic sclk,
   output logic sdata_in
);
   // Start to start spacing for the full-accuracy host rate
   localparam longint START_GAP_NS = 1000000 / 117;
   longint last_rise = -START_GAP_NS;

   initial
   begin
      hw_start_n = 1'b1;
      write_frame_sync_n = 1'b1;
      sclk = 1'b1;
      sdata_in = 1'b0;
   end

   task automatic step(input int n);
      repeat (n) @(posedge ref_clk);
      #1;
   endtask

   ////////////////////////////////////////////////////////////////
   // Five bits msb first, frame ends after nfalls clock falls
   task automatic write_word(input logic [4:0] word, input int nfalls);
      logic [5:0] sh;
      sh = {word, 1'b0};
      step(1);
      write_frame_sync_n = 1'b0;
      for (int i = 0; i < nfalls; i++)
      begin
         sdata_in = sh[5];
         sh = sh << 1;
         step(2);
         sclk = 1'b0;
         step(2);
         sclk = 1'b1;
      end
      step(2);
      write_frame_sync_n = 1'b1;
      // Released data line shows no stale value
      sdata_in = ~sdata_in;
   endtask

   ////////////////////////////////////////////////////////////////
   // Low pulse, rising edge is the start request
   task automatic pulse_start();
      while (longint'($time) - last_rise < START_GAP_NS)
         step(1);
      step(1);
      hw_start_n = 1'b0;
      step(3);
      hw_start_n = 1'b1;
      last_rise = longint'($time);
   endtask
endmodule

// ===== testbench/tb_top.sv
`timescale 1ns/1ps
module tb_top;
   import acs_pkg::*;
   localparam int SETTLE = 40;
   logic ref_clk, rst, hw_start_n, write_frame_sync_n, sclk, sdata_in, clk_in, self_clock_mode;
   logic settle_cap_pin, soft_start_bit, standby, soft_start_bit_hold, busy, done;
   logic [CODE_W-1:0] sample_code, result;
   logic [CHAN_W-1:0] chan_sel;
   int num_errors = 0;
   int n_checks = 0;
   int n;

   acs_sequencer #(.SETTLE_CYCLES(SETTLE), .BIPOLAR(1'b1)) i_acs_sequencer (
      .ref_clk(ref_clk), .rst(rst), .hw_start_n(hw_start_n), .write_frame_sync_n(write_frame_sync_n),
      .sclk(sclk), .sdata_in(sdata_in), .clk_in(clk_in), .self_clock_mode(self_clock_mode),
      .sample_code(sample_code), .settle_cap_pin(settle_cap_pin), .chan_sel(chan_sel),
      .soft_start_bit(soft_start_bit), .standby(standby), .soft_start_bit_hold(soft_start_bit_hold), .busy(busy),
      .result(result), .done(done));

   acs_host_model i_acs_host_model (
      .ref_clk(ref_clk), .hw_start_n(hw_start_n), .write_frame_sync_n(write_frame_sync_n),
      .sclk(sclk), .sdata_in(sdata_in));

   initial
   begin
      ref_clk = 1'b0;
      forever #10 ref_clk = ~ref_clk;
   end

   // Master clock, one transition every two cycles
   initial
   begin
      clk_in = 1'b0;
      forever
      begin
         repeat (2) @(posedge ref_clk);
         #1 clk_in = ~clk_in;
      end
   end

   ////////////////////////////////////////////////////////////////
   task automatic step(input int k);
      repeat (k) @(posedge ref_clk);
      #1;
   endtask

   task automatic chk(input logic [11:0] seen, input logic [11:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         num_errors++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask

   task automatic wait_lvl(ref logic s, input logic lvl, input int lim, output int cnt);
      cnt = 0;
      while (s !== lvl && cnt < lim)
      begin
         step(1);
         cnt++;
      end
      if (cnt >= lim)
         chk(12'h0, 12'h1);
   endtask

   task automatic end_of_test();
      $display("checks=%0d errors=%0d", n_checks, num_errors);
      if (num_errors == 0 && n_checks > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   ////////////////////////////////////////////////////////////////
   task automatic run_soft_start_bit(input logic [11:0] code);
      int c;
      sample_code = code;
      step(500 / CLK_PERIOD_NS);
      i_acs_host_model.pulse_start();
      wait_lvl(soft_start_bit_hold, 1'b1, 10, c);
      chk(busy, 12'h1);
      wait_lvl(done, 1'b1, 400, c);
      chk(12'(c >= 56 && c <= SOFT_START_BIT_MAX_CYCLES), 12'h1);
      chk(result, code ^ 12'h800);
      chk(soft_start_bit_hold, 12'h0);
      wait_lvl(busy, 1'b0, 300, c);
      chk(12'(c >= ACQ_CYCLES - 2), 12'h1);
   endtask

   task automatic t_reset();
      chk(chan_sel, 12'h0);
      chk(soft_start_bit, 12'h0);
      chk(settle_cap_pin, 12'h1);
      chk({busy, soft_start_bit_hold, done}, 12'h0);
      chk(result, 12'h0);
      $display("reset test done");
   endtask

   task automatic t_write();
      for (int ch = 0; ch < 8; ch++)
      begin
         i_acs_host_model.write_word({3'(ch), 1'b0, 1'(ch)}, 6);
         chk(chan_sel, 12'(ch));
         chk(standby, 12'(ch % 2));
         chk(settle_cap_pin, 12'h0);
      end
      i_acs_host_model.pulse_start();
      step(4);
      chk(soft_start_bit_hold, 12'h0);
      wait_lvl(settle_cap_pin, 1'b1, SETTLE + 20, n);
      chk(12'(n >= SETTLE - 12), 12'h1);
      $display("write test done");
   endtask

   task automatic t_soft_start_bit();
      run_soft_start_bit(12'h000);
      run_soft_start_bit(12'hFFF);
      run_soft_start_bit(12'h7FF);
      $display("conversion test done");
   endtask

   task automatic t_abort();
      i_acs_host_model.write_word({3'h2, 2'b00}, 3);
      step(2);
      chk(chan_sel, 12'h7);
      chk(settle_cap_pin, 12'h1);
      i_acs_host_model.write_word({3'h3, 2'b00}, 5);
      step(2);
      chk(chan_sel, 12'h7);
      chk(settle_cap_pin, 12'h1);
      $display("abort test done");
   endtask

   task automatic t_soft();
      sample_code = 12'h123;
      i_acs_host_model.write_word({3'h1, 2'b10}, 6);
      chk(soft_start_bit, 12'h1);
      chk(soft_start_bit_hold, 12'h0);
      wait_lvl(soft_start_bit_hold, 1'b1, SETTLE + 20, n);
      chk(settle_cap_pin, 12'h1);
      wait_lvl(busy, 1'b0, 400, n);
      chk(result, 12'h923);
      i_acs_host_model.pulse_start();
      step(4);
      chk(soft_start_bit_hold, 12'h0);
      i_acs_host_model.write_word({3'h1, 2'b00}, 6);
      wait_lvl(settle_cap_pin, 1'b1, SETTLE + 20, n);
      run_soft_start_bit(12'h800);
      $display("soft start test done");
   endtask

   task automatic t_self();
      self_clock_mode = 1'b1;
      step(SELF_PACE_CYCLES);
      run_soft_start_bit(12'h456);
      i_acs_host_model.pulse_start();
      step(4);
      chk(soft_start_bit_hold, 12'h0);
      step(SELF_PACE_CYCLES);
      run_soft_start_bit(12'h001);
      self_clock_mode = 1'b0;
      $display("self clock test done");
   endtask

   initial
   begin
      rst = 1'b1;
      self_clock_mode = 1'b0;
      sample_code = 12'h000;
      step(20);
      rst = 1'b0;
      step(1);
      t_reset();
      t_write();
      t_soft_start_bit();
      t_abort();
      t_soft();
      t_self();
      end_of_test();
   end

   initial
   begin
      repeat (20000) @(posedge ref_clk);
      num_errors++;
      end_of_test();
   end
endmodule
